// ===== core/sbtc_timer.sv
/*
 * Sixteen bit timer/counter with prescaler, overflow flag, interrupt gating,
 * reset input from two capture/compare units and oscillator pin direction control.
 * Assumes one 40 MHz clock, a synchronous active-low reset, an Avalon-MM master with
 * waitrequest, and a count_clk_in pin that is asynchronous to clk_in.
 */
`timescale 1ns/10ps

// What this block does
// - Sixteen-bit count as two read/write bytes
// - Count up from zero, wrap after full
// - Wrap sets and holds overflow flag
// - Interrupt requested only with enable bit set
// - Control bit 1 selects count source
// - Timer mode counts each instruction cycle
// - Counter mode counts rising external edges
// - Count only while run bit set
// - Either capture/compare unit clears the count
// - Oscillator enable forces both pins input, only the upper pin on early parts
// - Programmable prescaler ahead of the count
// - Global peripheral enable also gates interrupt
module sbtc_timer (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [7:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire logic instr_cycle_in,
    input wire logic count_clk_in,
    input wire logic ccp_a_reset_in,
    input wire logic ccp_b_reset_in,
    input wire logic early_variant_in,
    output logic osc_pin_lower_oe_out,
    output logic osc_pin_upper_oe_out,
    output logic overflow_irq_out
);
    import sbtc_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [5:0] control_reg, control_next;
    logic [15:0] count_reg, count_next;
    logic [2:0] presc_reg, presc_next;
    logic overflow_reg, overflow_next;
    logic enable_reg, enable_next;
    logic gie_reg, gie_next;
    logic [1:0] port_dir_reg, port_dir_next;
    logic ack_reg, ack_next;
    logic [31:0] rdata_reg, rdata_next;
    logic ext_meta_reg, ext_sync_reg, ext_prev_reg;

    logic run_bit;
    logic src_counter;
    logic osc_en;
    sbtc_div_type div_sel;
    logic src_tick;
    logic ps_tick;
    logic inc;
    logic wrap;
    logic acc;
    logic wr_hit_low, wr_hit_high, rd_hit_req;
    logic no_override;

    // Byte-0 write strobe for one register offset
    function automatic logic wr_hit(input logic [7:0] off);
        wr_hit = avs_write_in && !ack_reg && avs_address_in == off && avs_byteenable_in[0];
    endfunction : wr_hit

    // Prescaler terminal count per division ratio
    function automatic logic ps_done(input logic [2:0] cnt, input sbtc_div_type d);
        unique case (d)
            SBTC_DIV1: ps_done = 1'b1;
            SBTC_DIV2: ps_done = cnt[0];
            SBTC_DIV4: ps_done = &cnt[1:0];
            SBTC_DIV8: ps_done = &cnt;
        endcase
    endfunction : ps_done

    // ------------------------------------------------------------
    // Control decode
    // ------------------------------------------------------------
    assign run_bit = control_reg[SBTC_RUN_BIT];
    assign src_counter = control_reg[SBTC_SRC_BIT];
    assign osc_en = control_reg[SBTC_OSC_BIT];
    assign div_sel = sbtc_div_type'(control_reg[SBTC_PS_LO +: 2]);
    assign acc = (avs_read_in || avs_write_in) && !ack_reg;
    assign wr_hit_low = wr_hit(SBTC_OFF_COUNT_LOW);
    assign wr_hit_high = wr_hit(SBTC_OFF_COUNT_HIGH);
    assign rd_hit_req = avs_read_in && !ack_reg && avs_address_in == SBTC_OFF_REQUEST;
    // High when neither a byte write nor the clear input overrides the count
    assign no_override = !wr_hit_low && !wr_hit_high && !ccp_a_reset_in && !ccp_b_reset_in;

    // Pin edge detect reads the second and third stages, never the metastable first one
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            ext_meta_reg <= 1'b0;
            ext_sync_reg <= 1'b0;
            ext_prev_reg <= 1'b0;
        end else begin
            ext_meta_reg <= count_clk_in;
            ext_sync_reg <= ext_meta_reg;
            ext_prev_reg <= ext_sync_reg;
        end
    end

    // ------------------------------------------------------------
    // Count path
    // ------------------------------------------------------------
    // Source select, prescale and increment
    always_comb begin
        src_tick = src_counter ? (ext_sync_reg && !ext_prev_reg) : instr_cycle_in;
        ps_tick = run_bit && src_tick && ps_done(presc_reg, div_sel);
        inc = ps_tick;
        wrap = inc && count_reg == SBTC_COUNT_FULL;
        presc_next = presc_reg;
        if (run_bit && src_tick) begin
            presc_next = ps_done(presc_reg, div_sel) ? 3'h0 : presc_reg + 3'h1;
        end
        count_next = count_reg;
        if (inc) begin
            count_next = count_reg + 16'h0001;
        end
        // Software write lands on top of an increment; clear input beats both
        if (wr_hit_low) begin
            count_next[7:0] = avs_writedata_in[7:0];
        end
        if (wr_hit_high) begin
            count_next[15:8] = avs_writedata_in[7:0];
        end
        if (ccp_a_reset_in || ccp_b_reset_in) begin
            count_next = SBTC_COUNT_RST;
        end
    end

    // ------------------------------------------------------------
    // Register file and overflow flag
    // ------------------------------------------------------------
    // Flag clears on read of the request register; a wrap in that same cycle wins
    always_comb begin
        control_next = control_reg;
        enable_next = enable_reg;
        gie_next = gie_reg;
        port_dir_next = port_dir_reg;
        overflow_next = overflow_reg;
        ack_next = acc;
        rdata_next = rdata_reg;
        if (wr_hit(SBTC_OFF_CONTROL)) begin
            control_next = avs_writedata_in[SBTC_CTRL_W-1:0];
        end
        if (wr_hit(SBTC_OFF_ENABLE)) begin
            enable_next = avs_writedata_in[SBTC_OVF_BIT];
        end
        if (wr_hit(SBTC_OFF_INT_CONTROL)) begin
            gie_next = avs_writedata_in[SBTC_GIE_BIT];
        end
        if (wr_hit(SBTC_OFF_PORT_DIR)) begin
            port_dir_next = avs_writedata_in[1:0];
        end
        if (rd_hit_req) begin
            overflow_next = 1'b0;
        end
        if (wrap) begin
            overflow_next = 1'b1;
        end
        if (avs_read_in && !ack_reg) begin
            unique case (avs_address_in)
                SBTC_OFF_COUNT_LOW: rdata_next = {24'h0, count_reg[7:0]};
                SBTC_OFF_COUNT_HIGH: rdata_next = {24'h0, count_reg[15:8]};
                SBTC_OFF_REQUEST: rdata_next = {31'h0, overflow_reg};
                SBTC_OFF_ENABLE: rdata_next = {31'h0, enable_reg};
                SBTC_OFF_CONTROL: rdata_next = {26'h0, control_reg};
                SBTC_OFF_INT_CONTROL: rdata_next = {25'h0, gie_reg, 6'h0};
                SBTC_OFF_PORT_DIR: rdata_next = {30'h0, port_dir_reg};
                default: rdata_next = SBTC_UNMAPPED_DATA;
            endcase
        end
    end

    // Registering of all software and count state
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            control_reg <= SBTC_CONTROL_RST;
            count_reg <= SBTC_COUNT_RST;
            presc_reg <= 3'h0;
            overflow_reg <= 1'b0;
            enable_reg <= 1'b0;
            gie_reg <= 1'b0;
            port_dir_reg <= 2'h3;
            ack_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            control_reg <= control_next;
            count_reg <= count_next;
            presc_reg <= presc_next;
            overflow_reg <= overflow_next;
            enable_reg <= enable_next;
            gie_reg <= gie_next;
            port_dir_reg <= port_dir_next;
            ack_reg <= ack_next;
            rdata_reg <= rdata_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Every access waits exactly one cycle, so read data is always registered
    assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !ack_reg;
    assign avs_readdata_out = rdata_reg;
    assign overflow_irq_out = overflow_reg && enable_reg && gie_reg;
    // Direction bit 1 means input; oscillator overrides them, early parts only the upper pin
    assign osc_pin_upper_oe_out = !osc_en && !port_dir_reg[1];
    assign osc_pin_lower_oe_out = (osc_en && !early_variant_in) ? 1'b0 : !port_dir_reg[0];

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_wrap;
        wrap && !rd_hit_req;
    endsequence

    chk_wrap_to_zero: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        wrap && !wr_hit_low && !wr_hit_high && !ccp_a_reset_in && !ccp_b_reset_in
        |=> count_reg == 16'h0000)
        else $error("count did not wrap to zero");
    chk_flag_set: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        s_wrap |=> overflow_reg)
        else $error("overflow flag not set on wrap");
    chk_flag_holds: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        overflow_reg && !rd_hit_req |=> overflow_reg)
        else $error("overflow flag dropped without read");
    chk_irq_gate: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        overflow_irq_out |-> enable_reg && overflow_reg)
        else $error("interrupt without enable");
    chk_irq_global: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !gie_reg |-> !overflow_irq_out)
        else $error("interrupt without global enable");
    chk_hold_stopped: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !run_bit && !wr_hit_low && !wr_hit_high && !ccp_a_reset_in && !ccp_b_reset_in
        |=> $stable(count_reg))
        else $error("count moved while stopped");
    chk_ccp_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        ccp_a_reset_in || ccp_b_reset_in |=> count_reg == 16'h0000)
        else $error("count not cleared by reset input");
    chk_osc_inputs: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        osc_en && !early_variant_in |-> !osc_pin_upper_oe_out && !osc_pin_lower_oe_out)
        else $error("oscillator pin driven");
    chk_low_write: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        wr_hit_low && !ccp_a_reset_in && !ccp_b_reset_in
        |=> count_reg[7:0] == $past(avs_writedata_in[7:0]))
        else $error("low byte write lost");
    chk_timer_step: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        run_bit && !src_counter && div_sel == SBTC_DIV1 && instr_cycle_in && !wr_hit_low
        && !wr_hit_high && !ccp_a_reset_in && !ccp_b_reset_in
        |=> count_reg == $past(count_reg) + 16'h0001)
        else $error("timer mode did not step");

    // Steps for the bus-wait check and the counter-step check
    sequence s_req_start;
        (avs_read_in || avs_write_in) && !ack_reg;
    endsequence
    sequence s_ext_rise;
        run_bit && src_counter && div_sel == SBTC_DIV1 && ext_sync_reg && !ext_prev_reg
        && no_override;
    endsequence

    chk_high_write: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        wr_hit_high && !ccp_a_reset_in && !ccp_b_reset_in
        |=> count_reg[15:8] == $past(avs_writedata_in[7:0]))
        else $error("high byte write lost");
    chk_counter_step: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        s_ext_rise |=> count_reg == $past(count_reg) + 16'h0001)
        else $error("counter mode did not step");
    // Stepping on the unselected source would show up as a move here
    chk_source_idle: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        run_bit && no_override
        && (src_counter ? !(ext_sync_reg && !ext_prev_reg) : !instr_cycle_in)
        |=> $stable(count_reg))
        else $error("count moved without a source tick");
    chk_presc_skip: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        run_bit && !src_counter && instr_cycle_in && div_sel != SBTC_DIV1 && presc_reg == 3'h0
        && no_override |=> $stable(count_reg))
        else $error("prescaler passed its first tick");
    chk_flag_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        rd_hit_req && !wrap |=> !overflow_reg)
        else $error("flag not cleared by read");
    chk_one_wait: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        s_req_start |-> avs_waitrequest_out ##1 !avs_waitrequest_out)
        else $error("bus wait not exactly one cycle");
    chk_upper_input: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        osc_en |-> !osc_pin_upper_oe_out)
        else $error("upper oscillator pin driven");
    chk_irq_raise: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        overflow_reg && enable_reg && gie_reg |-> overflow_irq_out)
        else $error("interrupt missing");
endmodule : sbtc_timer

// ===== core/sbtc_pkg.sv
/*
 * Constants for the sixteen bit timer/counter: register byte offsets, field positions,
 * reset values and prescaler encodings.
 * Assumes a 32-bit Avalon-MM slave with byte addresses and one register per aligned word.
 */
package sbtc_pkg;
    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] SBTC_OFF_CONTROL = 8'h10;
    localparam logic [7:0] SBTC_OFF_COUNT_LOW = 8'h00;
    localparam logic [7:0] SBTC_OFF_COUNT_HIGH = 8'h04;
    localparam logic [7:0] SBTC_OFF_REQUEST = 8'h08;
    localparam logic [7:0] SBTC_OFF_ENABLE = 8'h0c;
    localparam logic [7:0] SBTC_OFF_INT_CONTROL = 8'h14;
    localparam logic [7:0] SBTC_OFF_PORT_DIR = 8'h18;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int SBTC_RUN_BIT = 0;
    localparam int SBTC_SRC_BIT = 1;
    localparam int SBTC_OSC_BIT = 3;
    localparam int SBTC_PS_LO = 4;
    localparam int SBTC_OVF_BIT = 0;
    localparam int SBTC_GIE_BIT = 6;
    localparam int SBTC_CTRL_W = 6;

    // ------------------------------------------------------------
    // Reset values and fixed constants
    // ------------------------------------------------------------
    localparam logic [5:0] SBTC_CONTROL_RST = 6'h00;
    localparam logic [15:0] SBTC_COUNT_RST = 16'h0000;
    localparam logic [15:0] SBTC_COUNT_FULL = 16'hffff;
    localparam logic [31:0] SBTC_UNMAPPED_DATA = 32'h0000_0000;

    // Prescaler division ratio select
    typedef enum logic [1:0] {
        SBTC_DIV1 = 2'h0,
        SBTC_DIV2 = 2'h1,
        SBTC_DIV4 = 2'h2,
        SBTC_DIV8 = 2'h3
    } sbtc_div_type;
endpackage : sbtc_pkg

// ===== testbench/sbtc_ext_clock.sv
/*
 * Model of the external clock source on the counter input pin.
 * Assumes the bench asks for a burst of rising edges; the pin idles low between bursts.
 */
`timescale 1ns/10ps

module sbtc_ext_clock #(
    parameter int HALF_NS = 110
) (
    input wire logic start_in,
    input wire logic [7:0] edges_in,
    output logic count_clk_out
);
    // ----------------------------------------------------------------
    // Burst generator
    // ----------------------------------------------------------------
    initial count_clk_out = 1'b0;
    // Slow against clk_in, so every edge survives the two-stage sync
    always @(posedge start_in) begin
        repeat (edges_in) begin
            #(HALF_NS) count_clk_out = 1'b1;
            #(HALF_NS) count_clk_out = 1'b0;
        end
    end
endmodule : sbtc_ext_clock

// ===== testbench/sbtc_timer_test.sv
/*
 * Self-checking bench for the timer/counter: Avalon-MM tasks and directed tests.
 * Assumes the register map of sbtc_pkg and one wait cycle per bus access.
 */
`timescale 1ns/10ps

module sbtc_timer_test;
    import sbtc_pkg::*;
    logic clk_in, rst_n_in, avs_read_in, avs_write_in, avs_waitrequest_out;
    logic [7:0] avs_address_in, edges;
    logic [31:0] avs_writedata_in, avs_readdata_out, rd;
    logic [3:0] avs_byteenable_in;
    logic instr_cycle_in, count_clk_in, ccp_a_reset_in, ccp_b_reset_in, early_variant_in;
    logic osc_pin_lower_oe_out, osc_pin_upper_oe_out, overflow_irq_out, start;
    int n_mismatch = 0;
    int checks_done = 0;
    int cycles = 0;
    localparam logic [31:0] RUN = 32'h1 << SBTC_RUN_BIT;

    sbtc_timer uut (.clk_in(clk_in), .rst_n_in(rst_n_in), .avs_address_in(avs_address_in),
        .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
        .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
        .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
        .instr_cycle_in(instr_cycle_in), .count_clk_in(count_clk_in),
        .ccp_a_reset_in(ccp_a_reset_in), .ccp_b_reset_in(ccp_b_reset_in),
        .early_variant_in(early_variant_in), .osc_pin_lower_oe_out(osc_pin_lower_oe_out),
        .osc_pin_upper_oe_out(osc_pin_upper_oe_out), .overflow_irq_out(overflow_irq_out));
    sbtc_ext_clock ext (.start_in(start), .edges_in(edges), .count_clk_out(count_clk_in));

    // ----------------------------------------------------------------
    // Clock, timeout and shared tasks
    // ----------------------------------------------------------------
    always #12.5 clk_in = ~clk_in;
    // A hung handshake ends the run here instead of spinning forever
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : print_verdict
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    // Request is held until the edge at which waitrequest is seen low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        avs_write_in <= wr;
        avs_read_in <= ~wr;
        avs_address_in <= a;
        avs_writedata_in <= d;
        @(posedge clk_in);
        check(avs_waitrequest_out, 1'b1);
        do @(posedge clk_in); while (avs_waitrequest_out !== 1'b0);
        rd = avs_readdata_out;
        avs_write_in <= 1'b0;
        avs_read_in <= 1'b0;
    endtask : bus
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(rd, exp);
    endtask : rchk
    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge clk_in) instr_cycle_in <= 1'b1;
            @(posedge clk_in) instr_cycle_in <= 1'b0;
        end
    endtask : pulse

    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    initial begin
        {clk_in, rst_n_in, avs_read_in, avs_write_in, instr_cycle_in, start} = '0;
        {ccp_a_reset_in, ccp_b_reset_in, early_variant_in} = '0;
        {avs_address_in, avs_writedata_in, edges} = '0;
        avs_byteenable_in = 4'hf;
        repeat (3) @(posedge clk_in);
        rst_n_in <= 1'b1;
        rchk(SBTC_OFF_CONTROL, 32'h0);
        rchk(SBTC_OFF_PORT_DIR, 32'h3);
        rchk(8'h1c, SBTC_UNMAPPED_DATA);
        bus(1'b1, SBTC_OFF_COUNT_LOW, 32'h5a);
        bus(1'b1, SBTC_OFF_COUNT_HIGH, 32'ha5);
        rchk(SBTC_OFF_COUNT_LOW, 32'h5a);
        rchk(SBTC_OFF_COUNT_HIGH, 32'ha5);
        $display("registers test done");
        bus(1'b1, SBTC_OFF_COUNT_LOW, 32'hfe);
        bus(1'b1, SBTC_OFF_COUNT_HIGH, 32'hff);
        bus(1'b1, SBTC_OFF_CONTROL, RUN);
        pulse(1);
        rchk(SBTC_OFF_REQUEST, 32'h0);
        pulse(1);
        rchk(SBTC_OFF_COUNT_HIGH, 32'h0);
        bus(1'b1, SBTC_OFF_ENABLE, 32'h1);
        check(overflow_irq_out, 1'b0);
        bus(1'b1, SBTC_OFF_INT_CONTROL, 32'h1 << SBTC_GIE_BIT);
        check(overflow_irq_out, 1'b1);
        bus(1'b1, SBTC_OFF_ENABLE, 32'h0);
        check(overflow_irq_out, 1'b0);
        rchk(SBTC_OFF_REQUEST, 32'h1);
        rchk(SBTC_OFF_REQUEST, 32'h0);
        $display("overflow test done");
        bus(1'b1, SBTC_OFF_CONTROL, RUN | (32'h1 << SBTC_SRC_BIT));
        pulse(3);
        rchk(SBTC_OFF_COUNT_LOW, 32'h0);
        edges <= 8'd5;
        start <= 1'b1;
        repeat (90) @(posedge clk_in);
        rchk(SBTC_OFF_COUNT_LOW, 32'h5);
        bus(1'b1, SBTC_OFF_CONTROL, 32'h0);
        pulse(4);
        rchk(SBTC_OFF_COUNT_LOW, 32'h5);
        $display("source test done");
        for (int d = 0; d < 4; d++) begin
            bus(1'b1, SBTC_OFF_COUNT_LOW, 32'h0);
            bus(1'b1, SBTC_OFF_CONTROL, RUN | (d << SBTC_PS_LO));
            pulse(8);
            rchk(SBTC_OFF_COUNT_LOW, 32'h8 >> d);
        end
        $display("prescaler test done");
        @(posedge clk_in) ccp_a_reset_in <= 1'b1;
        @(posedge clk_in) ccp_a_reset_in <= 1'b0;
        rchk(SBTC_OFF_COUNT_LOW, 32'h0);
        bus(1'b1, SBTC_OFF_COUNT_LOW, 32'h33);
        @(posedge clk_in) ccp_b_reset_in <= 1'b1;
        @(posedge clk_in) ccp_b_reset_in <= 1'b0;
        rchk(SBTC_OFF_COUNT_LOW, 32'h0);
        bus(1'b1, SBTC_OFF_PORT_DIR, 32'h0);
        check({osc_pin_upper_oe_out, osc_pin_lower_oe_out}, 2'b11);
        bus(1'b1, SBTC_OFF_CONTROL, 32'h1 << SBTC_OSC_BIT);
        check({osc_pin_upper_oe_out, osc_pin_lower_oe_out}, 2'b00);
        @(posedge clk_in) early_variant_in <= 1'b1;
        @(posedge clk_in);
        check({osc_pin_upper_oe_out, osc_pin_lower_oe_out}, 2'b01);
        // Early parts need software to turn the lower pin into an input itself
        bus(1'b1, SBTC_OFF_PORT_DIR, 32'h1);
        check({osc_pin_upper_oe_out, osc_pin_lower_oe_out}, 2'b00);
        $display("reset and pin test done");
        print_verdict();
    end
endmodule : sbtc_timer_test
